/* File: rtl/scp_map.svh */
// constants for the serial configuration memory readout block
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

// ----------------------------------------
// storage
// ----------------------------------------
`define SCP_WORD_BITS     32
`define SCP_DEPTH_DEFAULT 4096
`define SCP_BIT_MSB       5'h1F
`define SCP_BIT_RST       5'h00
`define SCP_ERASED_WORD   32'hFFFFFFFF
`define SCP_POL_LOW_CODE  32'h00000000

// ----------------------------------------
// pin synchroniser bit positions
// ----------------------------------------
`define SCP_PIN_COUNT     5
`define SCP_PIN_SCLK      0
`define SCP_PIN_CE_N      1
`define SCP_PIN_RSTOE     2
`define SCP_PIN_DATA      3
`define SCP_PIN_VPP       4
`define SCP_SYNC_RST      5'h02

// ----------------------------------------
// programming entry
// ----------------------------------------
`define SCP_VPP_EDGES     2'h2
`define SCP_VPP_CNT_RST   2'h0

`endif

/* File: rtl/scp_pkg.sv */
// types of the serial configuration memory readout block
package scp_pkg;

    // cascade select sequencing after end of array
    typedef enum logic [1:0] {
        SCP_CAS_RUN,
        SCP_CAS_LOW,
        SCP_CAS_FOLLOW
    } scp_cas_t;

    // read or programming mode
    typedef enum logic [1:0] {
        SCP_MODE_READ,
        SCP_MODE_VPP,
        SCP_MODE_PROG
    } scp_mode_t;

endpackage

/* File: rtl/scp_readout.sv */
// serial configuration memory read and program logic
`timescale 1ns/10ps
`include "scp_map.svh"

module scp_readout
    import scp_pkg::*;
#(
    parameter int DEPTH_WORDS = `SCP_DEPTH_DEFAULT
) (
    // clock and reset
    input  wire logic CLK_IN,
    input  wire logic RESETN_IN,
    // serial pins from the loader
    input  wire logic SCLK_IN,
    input  wire logic CE_N_IN,
    input  wire logic RESET_OE_IN,
    input  wire logic VPP_HIGH_IN,
    // data pin, three signals
    input  wire logic DATA_IN,
    output logic      DATA_OUT,
    output logic      DATA_OE_OUT,
    // cascade and status
    output logic      CASCADE_SELECT_OUT_N,
    output logic      STANDBY_OUT
);

    // ----------------------------------------
    // parameters and checks
    // ----------------------------------------
    localparam int AW = $clog2(DEPTH_WORDS + 1);
    localparam logic [AW-1:0] LAST_ADDR = AW'(DEPTH_WORDS - 1);
    localparam logic [AW-1:0] OVF_ADDR  = AW'(DEPTH_WORDS);
    localparam logic [AW-1:0] ADDR_RST  = '0;
    // any depth of one word or more serves; parts are built with 1134, 2048 or 4096
    generate
        if (DEPTH_WORDS < 1) begin : g_bad_depth
            $error("DEPTH_WORDS must be at least 1");
        end
    endgenerate

    // ----------------------------------------
    // functions
    // ----------------------------------------
    // pin level seen as counter-clear
    function automatic logic clear_level(input logic pin,
                                         input logic pol_high);
        clear_level = pol_high ? pin : ~pin;
    endfunction

    // ----------------------------------------
    // storage array, erased to ones
    // ----------------------------------------
    // one overflow word beyond the array holds the polarity code
    logic [`SCP_WORD_BITS-1:0] mem [0:DEPTH_WORDS];
    logic                      mem_we;
    logic [AW-1:0]             mem_wa;
    logic [`SCP_WORD_BITS-1:0] mem_wd;
    // contents survive reset, so no reset branch here
    initial begin
        for (int i = 0; i <= DEPTH_WORDS; i++) begin
            mem[i] = `SCP_ERASED_WORD;
        end
    end
    // plain always: the initial block above also writes the array
    always @(posedge CLK_IN) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [`SCP_PIN_COUNT-1:0] pins;
    logic [`SCP_PIN_COUNT-1:0] sync1_reg;
    logic [`SCP_PIN_COUNT-1:0] sync2_reg;
    logic                      sclk_prev_reg;
    assign pins[`SCP_PIN_SCLK]  = SCLK_IN;
    assign pins[`SCP_PIN_CE_N]  = CE_N_IN;
    assign pins[`SCP_PIN_RSTOE] = RESET_OE_IN;
    assign pins[`SCP_PIN_DATA]  = DATA_IN;
    assign pins[`SCP_PIN_VPP]   = VPP_HIGH_IN;
    // chip select idles high so the part starts in standby
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            sync1_reg     <= `SCP_SYNC_RST;
            sync2_reg     <= `SCP_SYNC_RST;
            sclk_prev_reg <= 1'b0;
        end else begin
            sync1_reg     <= pins;
            sync2_reg     <= sync1_reg;
            sclk_prev_reg <= sync2_reg[`SCP_PIN_SCLK];
        end
    end
    logic sclk_rise;
    logic ce_n_s;
    logic rstoe_s;
    logic din_s;
    logic vpp_s;
    // one action per serial clock rise
    assign sclk_rise = sync2_reg[`SCP_PIN_SCLK] & ~sclk_prev_reg;
    assign ce_n_s    = sync2_reg[`SCP_PIN_CE_N];
    assign rstoe_s   = sync2_reg[`SCP_PIN_RSTOE];
    assign din_s     = sync2_reg[`SCP_PIN_DATA];
    assign vpp_s     = sync2_reg[`SCP_PIN_VPP];

    // ----------------------------------------
    // polarity from overflow word
    // ----------------------------------------
    logic pol_high_reg;
    logic pol_high_next;
    // zeros select active low, anything else active high
    always_comb begin
        pol_high_next = (mem[OVF_ADDR] != `SCP_POL_LOW_CODE);
    end
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            pol_high_reg <= 1'b1;
        end else begin
            pol_high_reg <= pol_high_next;
        end
    end
    logic ctr_clear;
    logic oe_act;
    // clear level on the combined input
    assign ctr_clear = clear_level(rstoe_s, pol_high_reg);
    assign oe_act    = ~ctr_clear;

    // ----------------------------------------
    // mode, counters and shift register
    // ----------------------------------------
    scp_mode_t                 mode_reg;
    scp_mode_t                 mode_next;
    logic [1:0]                vpp_cnt_reg;
    logic [1:0]                vpp_cnt_next;
    logic [AW-1:0]             addr_reg;
    logic [AW-1:0]             addr_next;
    logic [4:0]                bit_reg;
    logic [4:0]                bit_next;
    logic [`SCP_WORD_BITS-1:0] shin_reg;
    logic [`SCP_WORD_BITS-1:0] shin_next;
    scp_cas_t                  cas_reg;
    scp_cas_t                  cas_next;
    logic                      last_bit;
    assign last_bit = (addr_reg == LAST_ADDR) && (bit_reg == `SCP_BIT_MSB);
    always_comb begin
        mode_next    = mode_reg;
        vpp_cnt_next = vpp_cnt_reg;
        addr_next    = addr_reg;
        bit_next     = bit_reg;
        shin_next    = shin_reg;
        cas_next     = cas_reg;
        mem_we       = 1'b0;
        mem_wa       = addr_reg;
        mem_wd       = mem[addr_reg] & shin_reg;
        case (mode_reg)
            SCP_MODE_READ: begin
                if (sclk_rise && vpp_s) begin
                    mode_next    = SCP_MODE_VPP;
                    vpp_cnt_next = 2'h1;
                end else if (ctr_clear) begin
                    addr_next = ADDR_RST;
                    bit_next  = `SCP_BIT_RST;
                end else if (sclk_rise && !ce_n_s &&
                             cas_reg == SCP_CAS_RUN) begin
                    // advance, end of array sets cascade
                    if (last_bit) begin
                        cas_next = SCP_CAS_LOW;
                    end else if (bit_reg == `SCP_BIT_MSB) begin
                        bit_next  = `SCP_BIT_RST;
                        addr_next = addr_reg + AW'(1);
                    end else begin
                        bit_next = bit_reg + 5'h01;
                    end
                end
                // standby: address and bit count do not advance with chip select high
            end
            SCP_MODE_VPP: begin
                if (sclk_rise) begin
                    if (vpp_s) begin
                        if (vpp_cnt_reg != `SCP_VPP_EDGES) begin
                            vpp_cnt_next = vpp_cnt_reg + 2'h1;
                        end
                    end else if (vpp_cnt_reg == `SCP_VPP_EDGES) begin
                        mode_next = SCP_MODE_PROG;
                        addr_next = ADDR_RST;
                        bit_next  = `SCP_BIT_RST;
                        shin_next = `SCP_ERASED_WORD;
                    end else begin
                        mode_next = SCP_MODE_READ;
                    end
                end
            end
            SCP_MODE_PROG: begin
                if (!ce_n_s && !rstoe_s) begin
                    // leaving programming restarts the stream
                    mode_next    = SCP_MODE_READ;
                    vpp_cnt_next = `SCP_VPP_CNT_RST;
                    addr_next    = ADDR_RST;
                    bit_next     = `SCP_BIT_RST;
                    cas_next     = SCP_CAS_RUN;
                end else if (sclk_rise && ce_n_s && !rstoe_s) begin
                    if (addr_reg != OVF_ADDR) begin
                        addr_next = addr_reg + AW'(1);
                    end
                    bit_next = `SCP_BIT_RST;
                end else if (sclk_rise && ce_n_s && rstoe_s) begin
                    // shift in, burn the word at the boundary
                    shin_next = {shin_reg[`SCP_WORD_BITS-2:0], din_s};
                    if (bit_reg == `SCP_BIT_MSB) begin
                        mem_we    = 1'b1;
                        mem_wd    = mem[addr_reg] &
                                    {shin_reg[`SCP_WORD_BITS-2:0], din_s};
                        shin_next = `SCP_ERASED_WORD;
                        bit_next  = `SCP_BIT_RST;
                        if (addr_reg != OVF_ADDR) begin
                            addr_next = addr_reg + AW'(1);
                        end
                    end else begin
                        bit_next = bit_reg + 5'h01;
                    end
                end else if (sclk_rise && !ce_n_s && rstoe_s) begin
                    // verify read out of the word at the current address
                    if (bit_reg == `SCP_BIT_MSB) begin
                        bit_next = `SCP_BIT_RST;
                        if (addr_reg != OVF_ADDR) begin
                            addr_next = addr_reg + AW'(1);
                        end
                    end else begin
                        bit_next = bit_reg + 5'h01;
                    end
                end
            end
            default: begin
                mode_next = SCP_MODE_READ;
            end
        endcase
        // cascade select sequence after end of array
        if (mode_reg == SCP_MODE_READ) begin
            case (cas_reg)
                SCP_CAS_RUN: begin
                end
                SCP_CAS_LOW: begin
                    if (ce_n_s || !oe_act) begin
                        cas_next = SCP_CAS_FOLLOW;
                    end
                end
                SCP_CAS_FOLLOW: begin
                    if (!oe_act) begin
                        cas_next = SCP_CAS_RUN;
                    end
                end
                default: begin
                    cas_next = SCP_CAS_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            mode_reg    <= SCP_MODE_READ;
            vpp_cnt_reg <= `SCP_VPP_CNT_RST;
            addr_reg    <= ADDR_RST;
            bit_reg     <= `SCP_BIT_RST;
            shin_reg    <= `SCP_ERASED_WORD;
            cas_reg     <= SCP_CAS_RUN;
        end else begin
            mode_reg    <= mode_next;
            vpp_cnt_reg <= vpp_cnt_next;
            addr_reg    <= addr_next;
            bit_reg     <= bit_next;
            shin_reg    <= shin_next;
            cas_reg     <= cas_next;
        end
    end

    // ----------------------------------------
    // output pins
    // ----------------------------------------
    logic dout_reg;
    logic dout_next;
    logic doe_reg;
    logic doe_next;
    logic cso_n_reg;
    logic cso_n_next;
    logic stby_reg;
    logic stby_next;
    always_comb begin
        // msb first from the addressed word
        dout_next = mem[addr_next][`SCP_BIT_MSB - bit_next];
        doe_next  = 1'b0;
        stby_next = ce_n_s;
        if (mode_next == SCP_MODE_PROG) begin
            // output only for verify, input otherwise
            doe_next = ~ce_n_s & rstoe_s;
        end else if (mode_next == SCP_MODE_READ) begin
            // both enables and not past the end
            doe_next = ~ce_n_s & oe_act & (cas_next == SCP_CAS_RUN);
        end
        case (cas_next)
            SCP_CAS_LOW: begin
                cso_n_next = 1'b0;
            end
            SCP_CAS_FOLLOW: begin
                cso_n_next = ce_n_s | ctr_clear;
            end
            default: begin
                cso_n_next = 1'b1;
            end
        endcase
        if (mode_next == SCP_MODE_PROG) begin
            cso_n_next = pol_high_reg;
        end
    end
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            dout_reg  <= 1'b0;
            doe_reg   <= 1'b0;
            cso_n_reg <= 1'b1;
            stby_reg  <= 1'b1;
        end else begin
            dout_reg  <= dout_next;
            doe_reg   <= doe_next;
            cso_n_reg <= cso_n_next;
            stby_reg  <= stby_next;
        end
    end
    // downstream parts see this as their chip select
    assign CASCADE_SELECT_OUT_N = cso_n_reg;
    assign DATA_OUT             = dout_reg;
    assign DATA_OE_OUT          = doe_reg;
    assign STANDBY_OUT          = stby_reg;

endmodule

/* File: test/scp_readout_sva.sv */
// pin-level assertions for the serial memory readout block
`timescale 1ns/10ps
module scp_readout_chk #(
    parameter int DEPTH_WORDS = 4096
) (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    input wire logic SCLK_IN,
    input wire logic CE_N_IN,
    input wire logic RESET_OE_IN,
    input wire logic VPP_HIGH_IN,
    input wire logic DATA_IN,
    input wire logic DATA_OUT,
    input wire logic DATA_OE_OUT,
    input wire logic CASCADE_SELECT_OUT_N,
    input wire logic STANDBY_OUT
);
    // ----
    // warm-up
    // ----
    // pin history is stale for a few edges after reset
    logic [2:0] warm_reg;
    logic [2:0] warm_next;
    always_comb warm_next = (warm_reg == 3'h7) ? warm_reg : warm_reg + 3'h1;
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) warm_reg <= 3'h0;
        else warm_reg <= warm_next;
    end
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN || warm_reg != 3'h7);
    // ----
    // assertions
    // ----
    chk_oe_needs_ce: assert property (
        DATA_OE_OUT |-> !$past(CE_N_IN, 3))
        else $error("data driven without chip select");
    chk_standby_level: assert property (
        $past(CE_N_IN, 3) == $past(CE_N_IN, 4) |->
        STANDBY_OUT == $past(CE_N_IN, 3))
        else $error("standby flag does not follow chip select");
    chk_standby_floats: assert property (
        STANDBY_OUT |-> !DATA_OE_OUT)
        else $error("data driven in standby");
    chk_data_stands: assert property (
        $past(DATA_OE_OUT) && DATA_OE_OUT &&
        !($past(SCLK_IN, 3) && !$past(SCLK_IN, 6)) |-> $stable(DATA_OUT))
        else $error("data bit changed without a clock rise");
    chk_end_releases: assert property (
        $fell(CASCADE_SELECT_OUT_N) && $past(DATA_OE_OUT) |-> !DATA_OE_OUT)
        else $error("data still driven when cascade asserted");
    chk_end_at_rise: assert property (
        $fell(CASCADE_SELECT_OUT_N) && $past(DATA_OE_OUT) |->
        $past(SCLK_IN, 3) && !$past(SCLK_IN, 6))
        else $error("cascade asserted without a clock rise");
    chk_float_means_end: assert property (
        $fell(DATA_OE_OUT) && $past(CE_N_IN, 3) == $past(CE_N_IN, 6) &&
        $past(RESET_OE_IN, 3) == $past(RESET_OE_IN, 6) |->
        $fell(CASCADE_SELECT_OUT_N))
        else $error("data released without cascade assert");
    chk_cascade_ce_high: assert property (
        $rose(STANDBY_OUT) && !$past(CASCADE_SELECT_OUT_N) |->
        CASCADE_SELECT_OUT_N)
        else $error("cascade does not follow chip select high");
    cov_end: cover property ($fell(CASCADE_SELECT_OUT_N));
    cov_drive: cover property ($rose(DATA_OE_OUT));
    cov_follow: cover property ($rose(STANDBY_OUT) && !CASCADE_SELECT_OUT_N);
endmodule

bind scp_readout scp_readout_chk #(.DEPTH_WORDS(DEPTH_WORDS)) u_chk (
    .CLK_IN(CLK_IN), .RESETN_IN(RESETN_IN), .SCLK_IN(SCLK_IN),
    .CE_N_IN(CE_N_IN), .RESET_OE_IN(RESET_OE_IN),
    .VPP_HIGH_IN(VPP_HIGH_IN), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT),
    .DATA_OE_OUT(DATA_OE_OUT), .STANDBY_OUT(STANDBY_OUT),
    .CASCADE_SELECT_OUT_N(CASCADE_SELECT_OUT_N));

/* File: test/scp_loader_model.sv */
// loader model: makes serial clock frames and collects bits
`timescale 1ns/10ps
module scp_loader_model (
    // clock and reset
    input  wire logic   clk_in,
    input  wire logic   rstn_in,
    // frame control and data pin
    input  wire logic   run_in,
    input  wire logic   data_in,
    // serial clock and captured bits
    output logic        sclk_out,
    output logic [31:0] shift_out,
    output int          rises_out
);
    // ----
    // clock phases
    // ----
    // three system clocks per phase, the least the pin sync allows
    logic [2:0] ph_reg;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ph_reg <= 3'h0;
            sclk_out <= 1'b0;
            shift_out <= 32'h0;
            rises_out <= 0;
        end else if (run_in || ph_reg != 3'h0) begin
            ph_reg <= (ph_reg == 3'h5) ? 3'h0 : ph_reg + 3'h1;
            if (ph_reg == 3'h2) begin
                sclk_out <= 1'b1;
                shift_out <= {shift_out[30:0], data_in};
                rises_out <= rises_out + 1;
            end
            if (ph_reg == 3'h5) sclk_out <= 1'b0;
        end
    end
endmodule

/* File: test/scp_readout_bench.sv */
// self-checking bench for the serial memory readout block
`timescale 1ns/10ps
`define CHK(got, exp) begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
        err_total++; \
        $display("wrong value at %0t got %h exp %h", $time, got, exp); \
    end \
end
module scp_readout_bench;
    // short array keeps the full read-through within the cycle budget
    localparam int DEPTH = 4;
    localparam logic [31:0] PAT = 32'hA53C96F1;
    logic clk, rstn, sclk, ce_n, roe, vpp, run, drv_en, drv_bit, last_q;
    logic d_out, d_oe, cas_n, stby;
    logic [31:0] shift;
    wire data_w;
    int rises, cyc, err_total, total_checks;
    // released pin shows the inverse of its last driven level
    assign data_w = d_oe ? d_out : (drv_en ? drv_bit : ~last_q);
    always @(posedge clk) if (d_oe) last_q <= d_out;
    always #10 clk = ~clk;
    scp_readout #(.DEPTH_WORDS(DEPTH)) uut (
        .CLK_IN(clk), .RESETN_IN(rstn), .SCLK_IN(sclk), .CE_N_IN(ce_n),
        .RESET_OE_IN(roe), .VPP_HIGH_IN(vpp), .DATA_IN(data_w),
        .DATA_OUT(d_out), .DATA_OE_OUT(d_oe),
        .CASCADE_SELECT_OUT_N(cas_n), .STANDBY_OUT(stby));
    scp_loader_model ldr (
        .clk_in(clk), .rstn_in(rstn), .run_in(run), .data_in(data_w),
        .sclk_out(sclk), .shift_out(shift), .rises_out(rises));
    // ----
    // helpers
    // ----
    task automatic stop_test;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic pulses(input int n);
        int s;
        s = rises;
        run <= 1'b1;
        while (rises < s + n) @(posedge clk);
        run <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task automatic set_pins(input logic c, input logic r);
        ce_n <= c;
        roe <= r;
        repeat (6) @(posedge clk);
    endtask
    task automatic enter_prog;
        set_pins(1'b1, 1'b1);
        vpp <= 1'b1;
        pulses(2);
        vpp <= 1'b0;
        pulses(1);
    endtask
    // ----
    // scenarios
    // ----
    task automatic t_program;
        enter_prog;
        `CHK(cas_n, 1'b1)
        drv_en <= 1'b1;
        for (int i = 31; i >= 0; i--) begin
            drv_bit <= PAT[i];
            pulses(1);
        end
        drv_en <= 1'b0;
        set_pins(1'b0, 1'b0);
        // verify read drives the pin inside programming mode
        enter_prog;
        set_pins(1'b0, 1'b1);
        `CHK(d_oe, 1'b1)
        pulses(32);
        `CHK(shift, PAT)
        set_pins(1'b0, 1'b0);
    endtask
    task automatic t_read;
        `CHK(d_oe, 1'b1)
        `CHK(d_out, PAT[31])
        pulses(32);
        `CHK(shift, PAT)
        pulses(32);
        `CHK(shift, 32'hFFFFFFFF)
    endtask
    task automatic t_clear;
        set_pins(1'b0, 1'b1);
        `CHK(d_oe, 1'b0)
        set_pins(1'b0, 1'b0);
        `CHK(d_out, PAT[31])
        pulses(32);
        `CHK(shift, PAT)
    endtask
    task automatic t_standby;
        set_pins(1'b0, 1'b1);
        set_pins(1'b0, 1'b0);
        pulses(4);
        // combined input held low, so standby keeps the count
        set_pins(1'b1, 1'b0);
        `CHK(d_oe, 1'b0)
        `CHK(stby, 1'b1)
        pulses(3);
        set_pins(1'b0, 1'b0);
        pulses(28);
        `CHK(shift[27:0], PAT[27:0])
    endtask
    task automatic t_end;
        set_pins(1'b0, 1'b1);
        set_pins(1'b0, 1'b0);
        pulses(DEPTH * 32);
        `CHK(shift, 32'hFFFFFFFF)
        `CHK(cas_n, 1'b0)
        `CHK(d_oe, 1'b0)
        set_pins(1'b1, 1'b0);
        `CHK(cas_n, 1'b1)
        set_pins(1'b0, 1'b0);
        `CHK(cas_n, 1'b0)
        set_pins(1'b0, 1'b1);
        set_pins(1'b0, 1'b0);
        `CHK(cas_n, 1'b1)
        pulses(32);
        `CHK(shift, PAT)
        `CHK(cas_n, 1'b1)
    endtask
    task automatic t_polarity;
        enter_prog;
        set_pins(1'b1, 1'b0);
        pulses(DEPTH);
        set_pins(1'b1, 1'b1);
        drv_en <= 1'b1;
        drv_bit <= 1'b0;
        pulses(32);
        drv_en <= 1'b0;
        set_pins(1'b0, 1'b0);
        `CHK(d_oe, 1'b0)
        set_pins(1'b0, 1'b1);
        `CHK(d_oe, 1'b1)
        `CHK(d_out, PAT[31])
        enter_prog;
        `CHK(cas_n, 1'b0)
    endtask
    // all scenarios together take about 2.8k cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            stop_test;
        end
    end
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        ce_n = 1'b1;
        roe = 1'b1;
        vpp = 1'b0;
        run = 1'b0;
        drv_en = 1'b0;
        drv_bit = 1'b0;
        last_q = 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_program;
        t_read;
        t_clear;
        t_standby;
        t_end;
        t_polarity;
        stop_test;
    end
endmodule
